// ### tcf_regs.sv
// Thermal, clock and load-current diagnostic registers of a four-channel amplifier.
// Assumes a simple register port on ref_clk_in and asynchronous sensor levels.
`timescale 1ns/10ps
`default_nettype none
`include "tcf_consts.svh"
module tcf_regs (
  input  wire logic                 ref_clk_in,
  input  wire logic                 sys_rst_in,
  input  wire logic                 reg_rd_en_in,
  input  wire logic                 reg_wr_en_in,
  input  wire tcf_pkg::tcf_byte_type reg_addr_in,
  input  wire tcf_pkg::tcf_byte_type reg_wdata_in,
  output tcf_pkg::tcf_byte_type      reg_rdata_out,
  output logic                      reg_rvalid_out,
  input  wire logic                 thermal_shutdown_in,
  input  wire tcf_pkg::tcf_chan_type chan_thermal_over_limit_in,
  input  wire logic                 sync_clock_error_in,
  input  wire logic                 clock_follower_mode_in,
  input  wire logic                 fault_signal_in,
  input  wire logic                 warning_signal_in,
  input  wire tcf_pkg::tcf_chan_type chan_load_current_fault_in,
  input  wire tcf_pkg::tcf_chan_type chan_load_current_warning_in,
  output tcf_pkg::tcf_chan_type      chan_run_enable_out
);
  import tcf_pkg::*;

  logic [`TCF_SYNC_WIDTH-1:0] sync_vec;
  logic         s_global_sd;
  tcf_chan_type s_chan_sd;
  logic         s_clk_err;
  logic         s_follower;
  logic         s_fault_sig;
  logic         s_warn_sig;
  tcf_chan_type s_cur_fault;
  tcf_chan_type s_cur_warn;

  // All sensor levels are asynchronous to ref_clk_in
  tcf_sync2 #(
    .WIDTH (`TCF_SYNC_WIDTH)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({thermal_shutdown_in, chan_thermal_over_limit_in, sync_clock_error_in,
                  clock_follower_mode_in, fault_signal_in, warning_signal_in,
                  chan_load_current_fault_in, chan_load_current_warning_in}),
    .sync_out   (sync_vec)
  );

  assign {s_global_sd, s_chan_sd, s_clk_err, s_follower, s_fault_sig, s_warn_sig,
          s_cur_fault, s_cur_warn} = sync_vec;

  logic         rd_event;
  logic         rd_cur_fault;
  logic         rd_cur_warn;
  logic         wr_clear;
  logic         follower_clk_err;
  tcf_byte_type live_status;

  assign rd_event     = reg_rd_en_in && (reg_addr_in == `TCF_OFS_EVENT_MEM);
  assign rd_cur_fault = reg_rd_en_in && (reg_addr_in == `TCF_OFS_CUR_FAULT_MEM);
  assign rd_cur_warn  = reg_rd_en_in && (reg_addr_in == `TCF_OFS_CUR_WARN_MEM);
  assign wr_clear     = reg_wr_en_in && (reg_addr_in == `TCF_OFS_FAULT_CLEAR);

  assign follower_clk_err = s_clk_err && s_follower;

  // Live view, nothing latched
  always_comb
  begin
    live_status                    = `TCF_RESET_BYTE;
    live_status[`TCF_BIT_WARN_SIG]  = s_warn_sig;
    live_status[`TCF_BIT_FAULT_SIG] = s_fault_sig;
    live_status[`TCF_BIT_CLOCK_ERR] = follower_clk_err;
    live_status[`TCF_BIT_GLOBAL_SD] = s_global_sd;
    live_status[`TCF_CHAN_MSB:0]    = s_chan_sd;
  end

  logic         ev_clk_r;
  logic         ev_clk_nxt;
  logic         ev_global_r;
  logic         ev_global_nxt;
  tcf_chan_type ev_chan_r;
  tcf_chan_type ev_chan_nxt;
  tcf_chan_type cur_fault_r;
  tcf_chan_type cur_fault_nxt;
  tcf_chan_type cur_warn_r;
  tcf_chan_type cur_warn_nxt;
  tcf_chan_type stopped_r;
  tcf_chan_type stopped_nxt;
  tcf_byte_type rdata_r;
  tcf_byte_type rdata_nxt;
  logic         rvalid_r;
  logic         rvalid_nxt;

  // Set always wins over a clear in the same cycle, so no event is lost.
  // Thermal memory is not read-clear; the 0x30 write clears it.
  always_comb
  begin
    ev_global_nxt = (ev_global_r && !wr_clear) || s_global_sd;
    ev_chan_nxt   = (wr_clear ? `TCF_RESET_CHAN : ev_chan_r) | s_chan_sd;
    ev_clk_nxt    = (ev_clk_r && !wr_clear) || follower_clk_err;
    cur_fault_nxt = (rd_cur_fault ? `TCF_RESET_CHAN : cur_fault_r) | s_cur_fault;
    cur_warn_nxt  = (rd_cur_warn ? `TCF_RESET_CHAN : cur_warn_r) | s_cur_warn;
    // Reading 0x14 does not restart a channel
    stopped_nxt   = (wr_clear ? `TCF_RESET_CHAN : stopped_r) | s_cur_fault;
  end

  always_comb
  begin
    rvalid_nxt = reg_rd_en_in;
    rdata_nxt  = `TCF_RESET_BYTE;
    case (reg_addr_in)
      `TCF_OFS_EVENT_MEM:
      begin
        rdata_nxt[`TCF_BIT_CLOCK_ERR] = ev_clk_r;
        rdata_nxt[`TCF_BIT_GLOBAL_SD] = ev_global_r;
        rdata_nxt[`TCF_CHAN_MSB:0]    = ev_chan_r;
      end
      `TCF_OFS_LIVE_STATUS:   rdata_nxt = live_status;
      `TCF_OFS_CUR_FAULT_MEM: rdata_nxt[`TCF_CHAN_MSB:0] = cur_fault_r;
      `TCF_OFS_CUR_WARN_MEM:  rdata_nxt[`TCF_CHAN_MSB:0] = cur_warn_r;
      default:                rdata_nxt = `TCF_RESET_BYTE;
    endcase
    if (!reg_rd_en_in)
    begin
      rdata_nxt = rdata_r;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      ev_global_r <= 1'b0;
      ev_clk_r    <= 1'b0;
      ev_chan_r   <= `TCF_RESET_CHAN;
      cur_fault_r <= `TCF_RESET_CHAN;
      cur_warn_r  <= `TCF_RESET_CHAN;
      stopped_r   <= `TCF_RESET_CHAN;
      rdata_r     <= `TCF_RESET_BYTE;
      rvalid_r    <= 1'b0;
    end
    else
    begin
      ev_global_r <= ev_global_nxt;
      ev_clk_r    <= ev_clk_nxt;
      ev_chan_r   <= ev_chan_nxt;
      cur_fault_r <= cur_fault_nxt;
      cur_warn_r  <= cur_warn_nxt;
      stopped_r   <= stopped_nxt;
      rdata_r     <= rdata_nxt;
      rvalid_r    <= rvalid_nxt;
    end
  end

  assign reg_rdata_out       = rdata_r;
  assign reg_rvalid_out      = rvalid_r;
  assign chan_run_enable_out = ~stopped_r;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence seq_clear_write;
    reg_wr_en_in && (reg_addr_in == `TCF_OFS_FAULT_CLEAR);
  endsequence

  sequence seq_fault_read;
    reg_rd_en_in && (reg_addr_in == `TCF_OFS_CUR_FAULT_MEM);
  endsequence

  a_global_sd_set: assert property (
    s_global_sd |=> ev_global_r)
    else $error("global shutdown not stored");

  a_global_sd_hold: assert property (
    ev_global_r && !wr_clear |=> ev_global_r)
    else $error("global shutdown memory dropped without clear");

  a_chan_sd_store: assert property (
    s_chan_sd[3] ##1 (reg_rd_en_in && reg_addr_in == `TCF_OFS_EVENT_MEM && !wr_clear)
      |=> reg_rdata_out[3])
    else $error("channel 1 shutdown not read at bit 3");

  a_clk_err_gate: assert property (
    !ev_clk_r && !s_follower |=> !ev_clk_r)
    else $error("clock fault stored outside follower mode");

  a_live_clock: assert property (
    reg_rd_en_in && reg_addr_in == `TCF_OFS_LIVE_STATUS
      |=> reg_rdata_out[5] == $past(s_clk_err && s_follower))
    else $error("live clock error bit wrong");

  a_live_signals: assert property (
    reg_rd_en_in && reg_addr_in == `TCF_OFS_LIVE_STATUS
      |=> reg_rdata_out == $past({s_warn_sig, s_fault_sig, s_clk_err && s_follower,
                                  s_global_sd, s_chan_sd}))
    else $error("live status byte wrong");

  a_fault_rd_clear: assert property (
    seq_fault_read ##0 (s_cur_fault == `TCF_RESET_CHAN) |=> cur_fault_r == `TCF_RESET_CHAN)
    else $error("fault memory not cleared by read");

  a_warn_rd_clear: assert property (
    reg_rd_en_in && reg_addr_in == `TCF_OFS_CUR_WARN_MEM && s_cur_warn == `TCF_RESET_CHAN
      |=> cur_warn_r == `TCF_RESET_CHAN)
    else $error("warning memory not cleared by read");

  a_fault_upper_zero: assert property (
    reg_rd_en_in && (reg_addr_in == `TCF_OFS_CUR_FAULT_MEM || reg_addr_in == `TCF_OFS_CUR_WARN_MEM)
      |=> reg_rdata_out[7:4] == 4'h0)
    else $error("reserved current memory bits not zero");

  a_no_restart_read: assert property (
    s_cur_fault[3] ##1 (!wr_clear)[*3] |-> !chan_run_enable_out[3])
    else $error("channel restarted without clear write");

  a_restart_clear: assert property (
    seq_clear_write ##0 (s_cur_fault == `TCF_RESET_CHAN) |=> chan_run_enable_out == 4'hF)
    else $error("clear write did not restart channels");
endmodule : tcf_regs
`default_nettype wire

// ### tcf_consts.svh
// Offsets, field positions and reset values of the thermal/current diagnostic bank.
// Assumes inclusion by bare name from the register bank source.
`ifndef TCF_CONSTS_SVH
`define TCF_CONSTS_SVH

`define TCF_OFS_EVENT_MEM     8'h12
`define TCF_OFS_LIVE_STATUS   8'h13
`define TCF_OFS_CUR_FAULT_MEM 8'h14
`define TCF_OFS_CUR_WARN_MEM  8'h15
`define TCF_OFS_FAULT_CLEAR   8'h30

`define TCF_BIT_WARN_SIG      7
`define TCF_BIT_FAULT_SIG     6
`define TCF_BIT_CLOCK_ERR     5
`define TCF_BIT_GLOBAL_SD     4
`define TCF_CHAN_MSB          3

`define TCF_RESET_BYTE        8'h00
`define TCF_RESET_CHAN        4'h0
`define TCF_SYNC_WIDTH        17

`endif

// ### tcf_pkg.sv
// Types shared by the thermal/current diagnostic bank.
// Assumes nothing of its surroundings.
package tcf_pkg;
  typedef logic [7:0] tcf_byte_type;
  typedef logic [3:0] tcf_chan_type;
endpackage : tcf_pkg

// ### tcf_sync2.sv
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no multi-bit coherence is given.
`timescale 1ns/10ps
`default_nettype none
module tcf_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : tcf_sync2
`default_nettype wire

// ### test_tcf_regs.sv
// Self-checking bench for the thermal/current diagnostic register bank.
// Assumes the bank's own one-cycle read/write strobes and two-flop sensor sync.
`timescale 1ns/10ps
`default_nettype none
module test_tcf_regs;
  import tcf_pkg::*;
  logic         ref_clk_in;
  logic         sys_rst_in;
  logic         rd_en;
  logic         wr_en;
  tcf_byte_type addr;
  tcf_byte_type wdata;
  tcf_byte_type rdata;
  logic         rvalid;
  logic         th_sd;
  tcf_chan_type ch_th;
  logic         sync_err;
  logic         follower;
  logic         fault_sig;
  logic         warn_sig;
  tcf_chan_type cur_fault;
  tcf_chan_type cur_warn;
  tcf_chan_type run_en;
  int           err_count;
  int           total_checks;
  int           cycles;

  tcf_regs u_dut (
    .ref_clk_in                  (ref_clk_in),
    .sys_rst_in                  (sys_rst_in),
    .reg_rd_en_in                (rd_en),
    .reg_wr_en_in                (wr_en),
    .reg_addr_in                 (addr),
    .reg_wdata_in                (wdata),
    .reg_rdata_out               (rdata),
    .reg_rvalid_out              (rvalid),
    .thermal_shutdown_in         (th_sd),
    .chan_thermal_over_limit_in  (ch_th),
    .sync_clock_error_in         (sync_err),
    .clock_follower_mode_in      (follower),
    .fault_signal_in             (fault_sig),
    .warning_signal_in           (warn_sig),
    .chan_load_current_fault_in  (cur_fault),
    .chan_load_current_warning_in(cur_warn),
    .chan_run_enable_out         (run_en)
  );

  initial
  begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic finish_test;
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // Ceiling well above the roughly 120 cycles the sequence needs
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_count = err_count + 1;
      finish_test();
    end
  end

  task automatic check(input tcf_byte_type seen, input tcf_byte_type exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Read answer lands one edge after the strobe
  task automatic rd(input tcf_byte_type a, input tcf_byte_type exp);
    @(posedge ref_clk_in) #1;
    rd_en = 1'b1;
    addr  = a;
    @(posedge ref_clk_in) #1;
    rd_en = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask : rd

  task automatic wr(input tcf_byte_type a);
    @(posedge ref_clk_in) #1;
    wr_en = 1'b1;
    addr  = a;
    wdata = 8'h5A;
    @(posedge ref_clk_in) #1;
    wr_en = 1'b0;
  endtask : wr

  // Sensor levels; six edges covers the sync and storage delay
  task automatic sense(input logic t, input tcf_chan_type c, input logic s, input logic f,
                       input logic fs, input logic ws, input tcf_chan_type cf,
                       input tcf_chan_type cw);
    @(posedge ref_clk_in) #1;
    {th_sd, ch_th, sync_err, follower, fault_sig, warn_sig} = {t, c, s, f, fs, ws};
    {cur_fault, cur_warn} = {cf, cw};
    repeat (6) @(posedge ref_clk_in);
    #1;
  endtask : sense

  initial
  begin
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    {sys_rst_in, rd_en, wr_en, addr, wdata} = {1'b1, 2'b00, 8'h00, 8'h00};
    {th_sd, ch_th, sync_err, follower, fault_sig, warn_sig} = 9'h000;
    {cur_fault, cur_warn} = 8'h00;
    repeat (20) @(posedge ref_clk_in);
    #1 sys_rst_in = 1'b0;
    check({4'h0, run_en}, 8'h0F);
    for (int i = 8'h12; i <= 8'h15; i++) rd(i[7:0], 8'h00);
    rd(8'h20, 8'h00);
    // Global plus channels 1 and 3 over limit
    sense(1'b1, 4'hA, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
    rd(8'h13, 8'h1A);
    rd(8'h12, 8'h1A);
    sense(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
    rd(8'h13, 8'h00);
    rd(8'h12, 8'h1A);
    wr(8'h31);
    rd(8'h12, 8'h1A);
    wr(8'h30);
    rd(8'h12, 8'h00);
    // Clock error ignored while not a follower
    sense(1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
    rd(8'h13, 8'h00);
    rd(8'h12, 8'h00);
    sense(1'b0, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0, 4'h0);
    rd(8'h13, 8'h60);
    sense(1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1, 4'h0, 4'h0);
    rd(8'h13, 8'h80);
    rd(8'h12, 8'h20);
    wr(8'h30);
    // Channel 1 current fault, channels 3 and 4 warning
    sense(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h8, 4'h3);
    check({4'h0, run_en}, 8'h07);
    sense(1'b0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 4'h0);
    rd(8'h14, 8'h08);
    rd(8'h14, 8'h00);
    rd(8'h15, 8'h03);
    rd(8'h15, 8'h00);
    check({4'h0, run_en}, 8'h07);
    wr(8'h30);
    check({4'h0, run_en}, 8'h0F);
    finish_test();
  end
endmodule : test_tcf_regs
`default_nettype wire
